// file: include/accr_pkg.sv
// Package for the channel calibration and configuration register group
// Overview of operation
// - Phase delay is 10-bit signed R/W in setup bits 15:6, reset zero.
// - Setup bit 2 bypasses this channel's DC filter; zero defers to global setting.
// - Setup bits 1:0 pick own pins, shorted, positive test or negative test.
// - High offset register holds offset bits 23:8, R/W, reset zero.
// - Low offset register holds offset bits 7:0 in 15:8; low byte reads zero.
// - High gain register holds gain bits 23:8, read/write.
// - Low gain register holds gain bits 7:0 in 15:8; low byte reads zero.
// - Gain coefficient is an unsigned fraction from zero to just under two.
// - High gain resets to 8000h; every other register resets to 0000h.
// - Setup bits 5:3 are reserved, ignore writes, read zero.
package accr_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 16;
  localparam int          COEF_W        = 24;
  localparam logic [7:0]  ADDR_SETUP    = 8'h1D;
  localparam logic [7:0]  ADDR_OFS_HI   = 8'h1E;
  localparam logic [7:0]  ADDR_OFS_LO   = 8'h1F;
  localparam logic [7:0]  ADDR_GAIN_HI  = 8'h20;
  localparam logic [7:0]  ADDR_GAIN_LO  = 8'h21;
  localparam logic [15:0] RST_ZERO      = 16'h0000;
  localparam logic [15:0] RST_GAIN_HI   = 16'h8000;
  localparam logic [9:0]  RST_PHASE     = 10'h000;
  localparam int          PHASE_LSB     = 6;
  localparam int          PHASE_MSB     = 15;
  localparam int          BYPASS_BIT    = 2;
  localparam int          SEL_MSB       = 1;
  localparam int          LOW_BYTE_MSB  = 15;
  localparam int          LOW_BYTE_LSB  = 8;

  // Input selector codes
  typedef enum logic [1:0] {
    ACCR_SEL_PINS  = 2'h0,
    ACCR_SEL_SHORT = 2'h1,
    ACCR_SEL_TPOS  = 2'h2,
    ACCR_SEL_TNEG  = 2'h3
  } accr_sel_type;

  // Channel setup fields as held in flops
  typedef struct packed {
    logic [9:0]   channel_phase_delay;
    logic         channel_dc_filter_bypass;
    accr_sel_type channel_input_select;
  } accr_setup_type;

  // Decoded input routing for the analog front end
  typedef struct packed {
    logic use_pins;
    logic shorted;
    logic test_pos;
    logic test_neg;
  } accr_route_type;
endpackage : accr_pkg

// file: sim/accr_regs_bench.sv
// Self-checking bench for the channel setup and calibration register bank
`timescale 1ns/100ps
module accr_regs_bench;
  logic                     clk_i    = 1'b0;
  logic                     arst_n_i = 1'b0;
  logic [7:0]               addr_i   = 8'h00;
  logic [15:0]              wdata_i  = 16'h0000;
  logic                     wr_i     = 1'b0;
  logic                     rd_i     = 1'b0;
  logic                     glob_i   = 1'b1;
  logic [15:0]              rdata_o;
  logic [9:0]               phase_o;
  logic                     filt_o;
  accr_pkg::accr_route_type route_o;
  logic [23:0]              ofs_o;
  logic [23:0]              gain_o;
  int                       n_fail      = 0;
  int                       check_count = 0;
  int                       cycles      = 0;

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  accr_regs dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .global_dc_filter_setting_i(glob_i), .rdata_o(rdata_o), .channel_phase_delay_o(phase_o),
    .dc_filter_enable_o(filt_o), .route_o(route_o), .offset_coeff_o(ofs_o), .gain_coeff_o(gain_o));

  // Hang guard, far above the 70 or so cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      results();
    end
  end

  task chk(input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write, then an idle edge so the strobe is never re-driven in the same step
  task wr(input logic [7:0] a, input logic [15:0] d);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample mid-cycle there
  task rd(input logic [7:0] a, input logic [15:0] exp);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdata_o, exp);
    @(posedge clk_i);
  endtask : rd

  task reset_check;
    rd(accr_pkg::ADDR_SETUP, 16'h0000);
    rd(accr_pkg::ADDR_OFS_HI, 16'h0000);
    rd(accr_pkg::ADDR_OFS_LO, 16'h0000);
    rd(accr_pkg::ADDR_GAIN_HI, 16'h8000);
    rd(accr_pkg::ADDR_GAIN_LO, 16'h0000);
    chk(gain_o, 24'h800000);
    chk(route_o, 24'h000008);
    chk(phase_o, 24'h000000);
    chk(filt_o, 24'h000001);
  endtask : reset_check

  task setup_check;
    wr(accr_pkg::ADDR_SETUP, 16'hFFFF);
    rd(accr_pkg::ADDR_SETUP, 16'hFFC7);
    chk(phase_o, 24'h0003FF);
    chk(filt_o, 24'h000000);
    // Every selector code, with the reserved bits written high each time
    for (int i = 0; i < 4; i++) begin
      wr(accr_pkg::ADDR_SETUP, {10'h201, 3'h7, 1'b0, i[1:0]});
      rd(accr_pkg::ADDR_SETUP, {10'h201, 3'h0, 1'b0, i[1:0]});
      chk(route_o, 24'h000008 >> i);
      chk(filt_o, 24'h000001);
    end
    chk(phase_o, 24'h000201);
    glob_i <= 1'b0;
    @(negedge clk_i);
    chk(filt_o, 24'h000000);
    @(posedge clk_i);
    glob_i <= 1'b1;
  endtask : setup_check

  task coeff_check;
    wr(accr_pkg::ADDR_OFS_HI, 16'hA5C3);
    wr(accr_pkg::ADDR_OFS_LO, 16'h7EFF);
    wr(accr_pkg::ADDR_GAIN_HI, 16'hFFFF);
    wr(accr_pkg::ADDR_GAIN_LO, 16'hFFFF);
    rd(accr_pkg::ADDR_OFS_HI, 16'hA5C3);
    rd(accr_pkg::ADDR_OFS_LO, 16'h7E00);
    rd(accr_pkg::ADDR_GAIN_HI, 16'hFFFF);
    rd(accr_pkg::ADDR_GAIN_LO, 16'hFF00);
    chk(ofs_o, 24'hA5C37E);
    chk(gain_o, 24'hFFFFFF);
    // Neighbouring unmapped places must neither store nor disturb
    wr(8'h22, 16'h1234);
    wr(8'h1C, 16'h5555);
    rd(8'h22, 16'h0000);
    rd(accr_pkg::ADDR_GAIN_HI, 16'hFFFF);
    rd(accr_pkg::ADDR_SETUP, 16'h8043);
  endtask : coeff_check

  // Reset in mid-run must restore phase, offset and gain, mid-scale gain included
  task rerun_check;
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(gain_o, 24'h800000);
    chk(ofs_o, 24'h000000);
    chk(phase_o, 24'h000000);
    @(posedge clk_i);
    rd(accr_pkg::ADDR_GAIN_HI, 16'h8000);
  endtask : rerun_check

  task results;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  initial begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    reset_check();
    setup_check();
    coeff_check();
    rerun_check();
    results();
  end
endmodule : accr_regs_bench

// file: src/accr_regs.sv
// Channel setup and calibration register bank
`timescale 1ns/100ps
module accr_regs (
  input  wire logic                             clk_i,          // 20 MHz clock
  input  wire logic                             arst_n_i,       // Async reset, active low
  input  wire logic [accr_pkg::ADDR_W-1:0]      addr_i,         // Register address
  input  wire logic [accr_pkg::DATA_W-1:0]      wdata_i,        // Write data
  input  wire logic                             wr_i,           // Write strobe
  input  wire logic                             rd_i,           // Read strobe
  input  wire logic                             global_dc_filter_setting_i, // Global filter enable
  output logic      [accr_pkg::DATA_W-1:0]      rdata_o,        // Read data, cycle after strobe
  output logic      [9:0]                       channel_phase_delay_o,      // Signed phase delay
  output logic                                  dc_filter_enable_o,         // Filter active here
  output accr_pkg::accr_route_type              route_o,        // Decoded input routing
  output logic      [accr_pkg::COEF_W-1:0]      offset_coeff_o, // Signed offset coefficient
  output logic      [accr_pkg::COEF_W-1:0]      gain_coeff_o    // Unsigned gain fraction
);

  // Register state
  accr_pkg::accr_setup_type setup, next_setup;
  logic [15:0] ofs_hi, next_ofs_hi;
  logic [7:0]  ofs_lo, next_ofs_lo;
  logic [15:0] gain_hi, next_gain_hi;
  logic [7:0]  gain_lo, next_gain_lo;
  logic [15:0] next_rdata;

  // Write decode; reserved setup bits 5:3 are simply not stored
  always_comb begin
    next_setup   = setup;
    next_ofs_hi  = ofs_hi;
    next_ofs_lo  = ofs_lo;
    next_gain_hi = gain_hi;
    next_gain_lo = gain_lo;
    if (wr_i) begin
      case (addr_i)
        accr_pkg::ADDR_SETUP: begin
          next_setup.channel_phase_delay      = wdata_i[accr_pkg::PHASE_MSB:accr_pkg::PHASE_LSB];
          next_setup.channel_dc_filter_bypass = wdata_i[accr_pkg::BYPASS_BIT];
          next_setup.channel_input_select     = accr_pkg::accr_sel_type'(wdata_i[accr_pkg::SEL_MSB:0]);
        end
        accr_pkg::ADDR_OFS_HI:  next_ofs_hi  = wdata_i;
        accr_pkg::ADDR_OFS_LO:  next_ofs_lo  = wdata_i[accr_pkg::LOW_BYTE_MSB:accr_pkg::LOW_BYTE_LSB];
        accr_pkg::ADDR_GAIN_HI: next_gain_hi = wdata_i;
        accr_pkg::ADDR_GAIN_LO: next_gain_lo = wdata_i[accr_pkg::LOW_BYTE_MSB:accr_pkg::LOW_BYTE_LSB];
        default: ;  // Unmapped writes are dropped
      endcase
    end
  end

  // Read mux; reserved bits and unmapped addresses read zero, data held otherwise zero
  always_comb begin
    next_rdata = accr_pkg::RST_ZERO;
    if (rd_i) begin
      case (addr_i)
        accr_pkg::ADDR_SETUP:   next_rdata = {setup.channel_phase_delay, 3'h0,
                                              setup.channel_dc_filter_bypass,
                                              setup.channel_input_select};
        accr_pkg::ADDR_OFS_HI:  next_rdata = ofs_hi;
        accr_pkg::ADDR_OFS_LO:  next_rdata = {ofs_lo, 8'h00};
        accr_pkg::ADDR_GAIN_HI: next_rdata = gain_hi;
        accr_pkg::ADDR_GAIN_LO: next_rdata = {gain_lo, 8'h00};
        default:                next_rdata = accr_pkg::RST_ZERO;
      endcase
    end
  end

  // State registers; gain high alone resets to mid-scale
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      setup.channel_phase_delay      <= accr_pkg::RST_PHASE;
      setup.channel_dc_filter_bypass <= 1'b0;
      setup.channel_input_select     <= accr_pkg::ACCR_SEL_PINS;
      ofs_hi  <= accr_pkg::RST_ZERO;
      ofs_lo  <= 8'h00;
      gain_hi <= accr_pkg::RST_GAIN_HI;
      gain_lo <= 8'h00;
      rdata_o <= accr_pkg::RST_ZERO;
    end else begin
      setup   <= next_setup;
      ofs_hi  <= next_ofs_hi;
      ofs_lo  <= next_ofs_lo;
      gain_hi <= next_gain_hi;
      gain_lo <= next_gain_lo;
      rdata_o <= next_rdata;
    end
  end

  // Outputs to the datapath from flops; filter enable also gated by the global input
  assign channel_phase_delay_o = setup.channel_phase_delay;
  // Per-channel bypass overrides; otherwise the global setting rules
  assign dc_filter_enable_o = global_dc_filter_setting_i & ~setup.channel_dc_filter_bypass;
  assign route_o.use_pins = (setup.channel_input_select == accr_pkg::ACCR_SEL_PINS);
  assign route_o.shorted  = (setup.channel_input_select == accr_pkg::ACCR_SEL_SHORT);
  assign route_o.test_pos = (setup.channel_input_select == accr_pkg::ACCR_SEL_TPOS);
  assign route_o.test_neg = (setup.channel_input_select == accr_pkg::ACCR_SEL_TNEG);
  // Gain is read as unsigned 1.23 fixed point: 8000h high is unity
  assign offset_coeff_o = {ofs_hi, ofs_lo};
  assign gain_coeff_o   = {gain_hi, gain_lo};

  // Checks
  a_setup_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == accr_pkg::ADDR_SETUP) |=> channel_phase_delay_o == $past(wdata_i[15:6]))
    else $error("phase delay not written");
  a_bypass_gate: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    setup.channel_dc_filter_bypass |-> !dc_filter_enable_o)
    else $error("bypass did not disable filter");
  a_route_onehot: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $onehot(route_o))
    else $error("routing not one-hot");
  a_ofs_hi_rd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == accr_pkg::ADDR_OFS_HI) |=> rdata_o == $past(offset_coeff_o[23:8]))
    else $error("offset high readback wrong");
  a_ofs_lo_rd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == accr_pkg::ADDR_OFS_LO) |=> rdata_o == {$past(ofs_lo), 8'h00})
    else $error("offset low readback wrong");
  a_gain_hi_wr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && addr_i == accr_pkg::ADDR_GAIN_HI) |=> gain_coeff_o[23:8] == $past(wdata_i))
    else $error("gain high not written");
  a_gain_lo_rd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == accr_pkg::ADDR_GAIN_LO) |=> rdata_o[7:0] == 8'h00)
    else $error("gain low reserved byte nonzero");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && addr_i == accr_pkg::ADDR_SETUP) |=> rdata_o[5:3] == 3'h0)
    else $error("reserved setup bits nonzero");
  a_gain_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(wr_i && (addr_i == accr_pkg::ADDR_GAIN_HI || addr_i == accr_pkg::ADDR_GAIN_LO))
    |=> $stable(gain_coeff_o))
    else $error("gain changed without write");

  // Address match for the checks below; one place for the decode
  function automatic logic accr_hit(input logic [accr_pkg::ADDR_W-1:0] a,
                                    input logic [accr_pkg::ADDR_W-1:0] r);
    return a == r;
  endfunction : accr_hit

  // Phase readback reflects the value held before the read edge
  a_phase_rdback: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && accr_hit(addr_i, accr_pkg::ADDR_SETUP))
    |=> rdata_o[15:6] == $past(setup.channel_phase_delay))
    else $error("phase readback wrong");

  // Phase must not drift without a setup write
  a_phase_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(wr_i && accr_hit(addr_i, accr_pkg::ADDR_SETUP))
    |=> $stable(channel_phase_delay_o))
    else $error("phase changed without write");

  // Phase comes out of reset at zero
  a_rst_phase: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i)
    |-> channel_phase_delay_o == accr_pkg::RST_PHASE)
    else $error("phase not zero after reset");

  // Bypass flag captures its write bit
  a_bypass_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && accr_hit(addr_i, accr_pkg::ADDR_SETUP))
    |=> setup.channel_dc_filter_bypass == $past(wdata_i[accr_pkg::BYPASS_BIT]))
    else $error("bypass not written");

  // With the bypass clear the global setting alone governs
  a_filter_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !setup.channel_dc_filter_bypass
    |-> dc_filter_enable_o == global_dc_filter_setting_i)
    else $error("filter not following global setting");

  // Bypass readback
  a_bypass_rdback: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && accr_hit(addr_i, accr_pkg::ADDR_SETUP))
    |=> rdata_o[2] == $past(setup.channel_dc_filter_bypass))
    else $error("bypass readback wrong");

  // Bypass holds between writes
  a_bypass_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(wr_i && accr_hit(addr_i, accr_pkg::ADDR_SETUP))
    |=> $stable(setup.channel_dc_filter_bypass))
    else $error("bypass changed without write");

  // Bypass clear after reset so the global setting rules
  a_rst_bypass: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i)
    |-> !setup.channel_dc_filter_bypass)
    else $error("bypass set after reset");

  // Selector captures its write bits
  a_sel_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && accr_hit(addr_i, accr_pkg::ADDR_SETUP))
    |=> setup.channel_input_select == $past(wdata_i[1:0]))
    else $error("selector not written");

  // Own pins routed for code 00
  a_sel_pins: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (setup.channel_input_select == accr_pkg::ACCR_SEL_PINS)
    |-> route_o.use_pins)
    else $error("pins not routed");

  // Inputs shorted for code 01
  a_sel_short: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (setup.channel_input_select == accr_pkg::ACCR_SEL_SHORT)
    |-> route_o.shorted)
    else $error("inputs not shorted");

  // Positive test signal for code 10
  a_sel_tpos: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (setup.channel_input_select == accr_pkg::ACCR_SEL_TPOS)
    |-> route_o.test_pos)
    else $error("positive test not routed");

  // Negative test signal for code 11
  a_sel_tneg: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (setup.channel_input_select == accr_pkg::ACCR_SEL_TNEG)
    |-> route_o.test_neg)
    else $error("negative test not routed");

  // Selector readback
  a_sel_rdback: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && accr_hit(addr_i, accr_pkg::ADDR_SETUP))
    |=> rdata_o[1:0] == $past(setup.channel_input_select))
    else $error("selector readback wrong");

  // Selector holds between writes; a glitch here would reroute the front end
  a_sel_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(wr_i && accr_hit(addr_i, accr_pkg::ADDR_SETUP))
    |=> $stable(route_o))
    else $error("routing changed without write");

  // Own pins selected after reset
  a_rst_sel: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i)
    |-> route_o.use_pins)
    else $error("pins not selected after reset");

  // Offset high half takes the whole write word
  a_ofs_hi_wr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && accr_hit(addr_i, accr_pkg::ADDR_OFS_HI))
    |=> offset_coeff_o[23:8] == $past(wdata_i))
    else $error("offset high not written");

  // Offset high half clear after reset
  a_rst_ofs_hi: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i)
    |-> offset_coeff_o[23:8] == accr_pkg::RST_ZERO)
    else $error("offset high not zero after reset");

  // Offset low byte takes write bits 15:8 only
  a_ofs_lo_wr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && accr_hit(addr_i, accr_pkg::ADDR_OFS_LO))
    |=> offset_coeff_o[7:0] == $past(wdata_i[15:8]))
    else $error("offset low not written");

  // Offset low reserved byte reads zero
  a_ofs_lo_rsv: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && accr_hit(addr_i, accr_pkg::ADDR_OFS_LO))
    |=> rdata_o[7:0] == 8'h00)
    else $error("offset low reserved byte nonzero");

  // Offset low byte clear after reset
  a_rst_ofs_lo: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i)
    |-> offset_coeff_o[7:0] == 8'h00)
    else $error("offset low not zero after reset");

  // Gain high readback
  a_gain_hi_rd: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && accr_hit(addr_i, accr_pkg::ADDR_GAIN_HI))
    |=> rdata_o == $past(gain_coeff_o[23:8]))
    else $error("gain high readback wrong");

  // Gain low byte takes write bits 15:8 only
  a_gain_lo_wr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && accr_hit(addr_i, accr_pkg::ADDR_GAIN_LO))
    |=> gain_coeff_o[7:0] == $past(wdata_i[15:8]))
    else $error("gain low not written");

  // Gain low data byte readback
  a_gain_lo_data: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_i && accr_hit(addr_i, accr_pkg::ADDR_GAIN_LO))
    |=> rdata_o[15:8] == $past(gain_coeff_o[7:0]))
    else $error("gain low readback wrong");

  // Gain low byte clear after reset
  a_rst_gain_lo: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i)
    |-> gain_coeff_o[7:0] == 8'h00)
    else $error("gain low not zero after reset");

  // Mid-scale gain after reset
  a_rst_gain_hi: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i)
    |-> gain_coeff_o[23:8] == accr_pkg::RST_GAIN_HI)
    else $error("gain high not mid-scale after reset");

  // Read data idle after reset
  a_rst_rdata: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(arst_n_i)
    |-> rdata_o == accr_pkg::RST_ZERO)
    else $error("read data not zero after reset");

  // Read data stand one cycle only, zero otherwise
  a_rdata_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !rd_i
    |=> rdata_o == accr_pkg::RST_ZERO)
    else $error("read data without read strobe");

  // Offset only moves on a write to one of its halves
  a_ofs_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !(wr_i && (accr_hit(addr_i, accr_pkg::ADDR_OFS_HI) || accr_hit(addr_i, accr_pkg::ADDR_OFS_LO)))
    |=> $stable(offset_coeff_o))
    else $error("offset changed without write");

  // High half updates on its own; the low half must not move
  a_ofs_split: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && accr_hit(addr_i, accr_pkg::ADDR_OFS_HI))
    |=> offset_coeff_o[7:0] == $past(offset_coeff_o[7:0]))
    else $error("offset low moved on high write");

  // Same independence for the gain halves
  a_gain_split: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && accr_hit(addr_i, accr_pkg::ADDR_GAIN_HI))
    |=> gain_coeff_o[7:0] == $past(gain_coeff_o[7:0]))
    else $error("gain low moved on high write");

  // Gain is unsigned, so a write of all ones must give the top code, just under two
  a_gain_top: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_i && accr_hit(addr_i, accr_pkg::ADDR_GAIN_HI) && wdata_i == 16'hFFFF)
    |=> gain_coeff_o[23:8] == 16'hFFFF)
    else $error("gain top code lost");

endmodule : accr_regs
